// >>> design/ccd_exec.v
// execution unit for watchdog kick, call, invert, clears and decrements
// assumes a register file with combinational read of file_addr_o and a
// fetch unit that offers one word at a time and honours ready_o
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_exec (
  input  wire                clock_i,
  input  wire                rst_i,
  input  wire                instr_valid_i,
  input  wire [`CCD_IW-1:0]  instr_i,
  input  wire [`CCD_PCW-1:0] pc_i,
  input  wire [`CCD_XW-1:0]  upper_pc_latch_i,
  input  wire [`CCD_XW-1:0]  file_rdata_i,
  input  wire                watchdog_timeout_i,
  input  wire                sleep_entry_i,
  input  wire                stack_pop_i,
  output wire                ready_o,
  output wire [`CCD_FAW-1:0] file_addr_o,
  output wire                file_we_o,
  output wire [`CCD_XW-1:0]  file_wdata_o,
  output wire [`CCD_XW-1:0]  accum_o,
  output wire                zero_flag_o,
  output wire                watchdog_expiry_flag_o,
  output wire                sleep_indicator_flag_o,
  output wire                watchdog_counter_clear_o,
  output wire                prescaler_clear_o,
  output wire                pc_load_o,
  output wire [`CCD_PCW-1:0] pc_target_o,
  output wire                discard_o,
  output wire [`CCD_PCW-1:0] stack_top_o
);

  // ----------------------------------------------------------------
  // states and operation classes
  // ----------------------------------------------------------------
  localparam ST_FETCH = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_CALL2 = 2'd2;

  localparam C_NOP   = 3'd0;
  localparam C_KICK  = 3'd1;
  localparam C_CALL  = 3'd2;
  localparam C_INV   = 3'd3;
  localparam C_ZFILE = 3'd4;
  localparam C_ZACC  = 3'd5;
  localparam C_DEC   = 3'd6;
  localparam C_DSKIP = 3'd7;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // sequencer and operands latched at acceptance
  reg [1:0]           state_q;
  reg [2:0]           cls_q;
  reg                 dest_q;
  reg [`CCD_KW-1:0]   target_q;
  reg [`CCD_PCW-1:0]  ret_pc_q;
  reg [1:0]           upper_q;
  reg                 skip_pend_q;
  // output registers
  reg                 ready_q;
  reg [`CCD_FAW-1:0]  faddr_q;
  reg                 fwe_q;
  reg [`CCD_XW-1:0]   fwdata_q;
  reg [`CCD_XW-1:0]   accum_q;
  reg                 zero_q;
  reg                 expiry_q;
  reg                 sleep_q;
  reg                 wdt_clr_q;
  reg                 pre_clr_q;
  reg                 pc_load_q;
  reg [`CCD_PCW-1:0]  pc_target_q;
  reg                 discard_q;

  // ----------------------------------------------------------------
  // decode of the offered instruction word
  // ----------------------------------------------------------------
  wire [5:0] op_fld   = instr_i[`CCD_OP_MSB:`CCD_OP_LSB];
  wire [2:0] call_fld = instr_i[`CCD_CALL_MSB:`CCD_CALL_LSB];
  reg  [2:0] dec_cls;

  // unknown words decode as nop and leave the accumulator, the file, the flags and the stack alone
  always @* begin
    dec_cls = C_NOP;
    // call is recognised by its top three bits before the opcode
    if (call_fld == `CCD_CALL_PFX) begin
      dec_cls = C_CALL;
    end else begin
      case (op_fld)
        `CCD_OP_KICK:  dec_cls = C_KICK;
        `CCD_OP_INV:   dec_cls = C_INV;
        `CCD_OP_ZFILE: dec_cls = C_ZFILE;
        `CCD_OP_ZACC:  dec_cls = C_ZACC;
        `CCD_OP_DEC:   dec_cls = C_DEC;
        `CCD_OP_DSKIP: dec_cls = C_DSKIP;
        default:       dec_cls = C_NOP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result datapath
  // ----------------------------------------------------------------
  wire [`CCD_XW-1:0] inv_res = ~file_rdata_i;
  wire [`CCD_XW-1:0] dec_res = file_rdata_i - `CCD_ONE8;
  reg  [`CCD_XW-1:0] result;

  // selects the value that goes to the chosen destination
  always @* begin
    case (cls_q)
      C_INV:   result = inv_res;
      C_DEC:   result = dec_res;
      C_DSKIP: result = dec_res;
      default: result = `CCD_ZERO8;
    endcase
  end

  wire res_zero = (result == `CCD_ZERO8);

  // ----------------------------------------------------------------
  // execute-slot qualifiers
  // ----------------------------------------------------------------
  // only the slot after acceptance changes results, the zero flag or the clear and load pulses
  wire exec_now   = (state_q == ST_EXEC);
  wire is_call    = (cls_q == C_CALL);
  wire is_kick    = (cls_q == C_KICK);
  wire is_dskip   = (cls_q == C_DSKIP);
  wire stack_push = exec_now && is_call;
  wire kick_now   = exec_now && is_kick;

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  // a pop in the push cycle is dropped so the push is never lost
  ccd_stack u_stack (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .push_i      (stack_push),
    .pop_i       (stack_pop_i && !stack_push),
    .push_data_i (ret_pc_q),
    .top_o       (stack_top_o)
  );

  // ----------------------------------------------------------------
  // sequencer: fetch slot, execute slot, second call slot
  // ----------------------------------------------------------------
  // accept edge: word and operands latched, ready drops
  // execute edge: results, flags and pulses land, ready returns
  // a call keeps ready low for one more edge
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_FETCH;
      ready_q     <= 1'b1;
      cls_q       <= C_NOP;
      dest_q      <= `CCD_DEST_ACC;
      target_q    <= `CCD_RST_K;
      ret_pc_q    <= `CCD_RST_PC;
      upper_q     <= `CCD_RST_UPPER;
      faddr_q     <= `CCD_RST_FADDR;
      skip_pend_q <= 1'b0;
      discard_q   <= 1'b0;
    end else begin
      discard_q <= 1'b0;
      case (state_q)
        ST_FETCH: begin
          if (instr_valid_i) begin
            state_q  <= ST_EXEC;
            ready_q  <= 1'b0;
            dest_q   <= instr_i[`CCD_DEST_BIT];
            target_q <= instr_i[`CCD_K_MSB:0];
            ret_pc_q <= pc_i + `CCD_PC_ONE;
            upper_q  <= upper_pc_latch_i[`CCD_LATCH_HI:`CCD_LATCH_LO];
            faddr_q  <= instr_i[`CCD_FA_MSB:0];
            // a word fetched behind a zero skip result runs as nop
            if (skip_pend_q) begin
              cls_q       <= C_NOP;
              skip_pend_q <= 1'b0;
              discard_q   <= 1'b1;
            end else begin
              cls_q <= dec_cls;
            end
          end
        end
        ST_EXEC: begin
          // call holds ready low for its second slot
          if (is_call) begin
            state_q <= ST_CALL2;
          end else begin
            state_q <= ST_FETCH;
            ready_q <= 1'b1;
          end
          // only a decrement-skip can arm the discard
          if (is_dskip) begin
            skip_pend_q <= res_zero;
          end
        end
        // second call slot: nothing moves but the sequencer
        ST_CALL2: begin
          state_q <= ST_FETCH;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= ST_FETCH;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // destination writes and zero flag
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fwe_q    <= 1'b0;
      fwdata_q <= `CCD_ZERO8;
      accum_q  <= `CCD_RST_ACC;
      zero_q   <= `CCD_RST_ZFLAG;
    end else begin
      fwe_q <= 1'b0;
      if (exec_now) begin
        case (cls_q)
          // computed results go to the selected destination
          C_INV, C_DEC, C_DSKIP: begin
            if (dest_q == `CCD_DEST_ACC) begin
              accum_q <= result;
            end else begin
              fwe_q    <= 1'b1;
              fwdata_q <= result;
            end
            // decrement-skip keeps every flag as it was
            if (cls_q != C_DSKIP) begin
              zero_q <= res_zero;
            end
          end
          // file clear: zero to the file register, zero flag set
          C_ZFILE: begin
            fwe_q    <= 1'b1;
            fwdata_q <= `CCD_ZERO8;
            zero_q   <= 1'b1;
          end
          // accumulator clear: zero to the accumulator, zero flag set
          C_ZACC: begin
            accum_q <= `CCD_ZERO8;
            zero_q  <= 1'b1;
          end
          // kick, call and nop leave the zero flag alone
          default: begin
            zero_q <= zero_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog side: kick pulses and the two status flags
  // ----------------------------------------------------------------
  // clear pulses stand for the execute edge of a kick only
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_clr_q <= 1'b0;
      pre_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= kick_now;
      pre_clr_q <= kick_now;
    end
  end

  // kick wins over a timeout or sleep entry in the same cycle
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      expiry_q <= `CCD_RST_STFLAG;
      sleep_q  <= `CCD_RST_STFLAG;
    end else if (kick_now) begin
      expiry_q <= 1'b1;
      sleep_q  <= 1'b1;
    end else begin
      // outside a kick the watchdog and sleep logic drop the flags
      if (watchdog_timeout_i) begin
        expiry_q <= 1'b0;
      end
      if (sleep_entry_i) begin
        sleep_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // program counter load for call
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_q   <= 1'b0;
      pc_target_q <= `CCD_RST_PC;
    end else begin
      pc_load_q <= stack_push;
      // target holds after the pulse for the fetch logic to read
      if (stack_push) begin
        pc_target_q <= {upper_q, target_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign ready_o                  = ready_q;
  assign file_addr_o              = faddr_q;
  assign file_we_o                = fwe_q;
  assign file_wdata_o             = fwdata_q;
  assign accum_o                  = accum_q;
  assign zero_flag_o              = zero_q;

  // watchdog side
  assign watchdog_expiry_flag_o   = expiry_q;
  assign sleep_indicator_flag_o   = sleep_q;
  assign watchdog_counter_clear_o = wdt_clr_q;
  assign prescaler_clear_o        = pre_clr_q;

  // program counter and discard side
  assign pc_load_o                = pc_load_q;
  assign pc_target_o              = pc_target_q;
  assign discard_o                = discard_q;

endmodule

// >>> design/ccd_consts.vh
// constants for the clear/call/decrement execution block
// assumes inclusion by bare name from every design file of the block
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CCD_IW          14
`define CCD_XW          8
`define CCD_FAW         7
`define CCD_PCW         13
`define CCD_KW          11
`define CCD_SPW         3
`define CCD_SDEPTH      8

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define CCD_OP_MSB      13
`define CCD_OP_LSB      8
`define CCD_DEST_BIT    7
`define CCD_FA_MSB      6
`define CCD_CALL_MSB    13
`define CCD_CALL_LSB    11
`define CCD_K_MSB       10
`define CCD_LATCH_HI    4
`define CCD_LATCH_LO    3

// ----------------------------------------------------------------
// operation encodings
// ----------------------------------------------------------------
`define CCD_CALL_PFX    3'h4
`define CCD_OP_INV      6'h11
`define CCD_OP_ZFILE    6'h12
`define CCD_OP_ZACC     6'h13
`define CCD_OP_DEC      6'h14
`define CCD_OP_DSKIP    6'h15
`define CCD_OP_KICK     6'h16

// ----------------------------------------------------------------
// values and reset values
// ----------------------------------------------------------------
`define CCD_ZERO8       8'h00
`define CCD_ONE8        8'h01
`define CCD_PC_ONE      13'h0001
`define CCD_RST_ACC     8'h00
`define CCD_RST_PC      13'h0000
`define CCD_RST_ZFLAG   1'b0
`define CCD_RST_STFLAG  1'b1
`define CCD_DEST_ACC    1'b0
`define CCD_RST_K       11'h000
`define CCD_RST_UPPER   2'h0
`define CCD_RST_FADDR   7'h00
`define CCD_RST_PTR     3'h0

`endif

// >>> design/ccd_stack.v
// return stack memory: eight entries, circular, top read from a register
// assumes push and pop from logic on the same clock, never both at once
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_stack (
  input  wire                clock_i,
  input  wire                rst_i,
  input  wire                push_i,
  input  wire                pop_i,
  input  wire [`CCD_PCW-1:0] push_data_i,
  output wire [`CCD_PCW-1:0] top_o
);

  reg [`CCD_PCW-1:0] mem_q [0:`CCD_SDEPTH-1];
  reg [`CCD_SPW-1:0] ptr_q;
  reg [`CCD_PCW-1:0] top_q;

  wire [`CCD_SPW-1:0] ptr_m1 = ptr_q - 3'h1;
  wire [`CCD_SPW-1:0] ptr_m2 = ptr_q - 3'h2;

  // ----------------------------------------------------------------
  // storage, one entry per generate step
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CCD_SDEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          mem_q[gi] <= `CCD_RST_PC;
        end else if (push_i && (ptr_q == gi)) begin
          mem_q[gi] <= push_data_i;
        end
      end
    end
  endgenerate

  // pointer wraps, so a ninth push overwrites the oldest entry
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q <= `CCD_RST_PTR;
      top_q <= `CCD_RST_PC;
    end else if (push_i) begin
      ptr_q <= ptr_q + 3'h1;
      top_q <= push_data_i;
    end else if (pop_i) begin
      ptr_q <= ptr_m1;
      top_q <= mem_q[ptr_m2];
    end else begin
      top_q <= mem_q[ptr_m1];
    end
  end

  assign top_o = top_q;

endmodule

// >>> tb/ccd_exec_checker.sv
// assertions on the ports of the execution unit
// assumes one clock and an async active-high reset; bound to ccd_exec
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_exec_checker (
  input wire        clock_i,
  input wire        rst_i,
  input wire        instr_valid_i,
  input wire [13:0] instr_i,
  input wire [12:0] pc_i,
  input wire [7:0]  upper_pc_latch_i,
  input wire [7:0]  file_rdata_i,
  input wire        ready_o,
  input wire        file_we_o,
  input wire [7:0]  file_wdata_o,
  input wire [7:0]  accum_o,
  input wire        zero_flag_o,
  input wire        watchdog_expiry_flag_o,
  input wire        sleep_indicator_flag_o,
  input wire        watchdog_counter_clear_o,
  input wire        prescaler_clear_o,
  input wire        pc_load_o,
  input wire [12:0] pc_target_o,
  input wire        discard_o,
  input wire [12:0] stack_top_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // taken words by kind; results show two edges later unless discarded
  wire        tk  = instr_valid_i && ready_o;
  wire [5:0]  op  = instr_i[13:8];
  wire        cl  = tk && instr_i[13:11] == `CCD_CALL_PFX;
  wire        kk  = tk && op == `CCD_OP_KICK;
  wire [1:0]  lat = upper_pc_latch_i[4:3];
  wire [10:0] kv  = instr_i[10:0];

  kick_clear_a: assert property (
    kk ##1 !discard_o |=> watchdog_counter_clear_o && prescaler_clear_o)
    else $error("kick gave no clear pulses");
  kick_flags_a: assert property (
    kk ##1 !discard_o |=> watchdog_expiry_flag_o && sleep_indicator_flag_o
      && $stable(zero_flag_o))
    else $error("kick flags wrong");
  call_target_a: assert property (
    cl ##1 !discard_o |=> pc_load_o && pc_target_o == {$past(lat, 2), $past(kv, 2)})
    else $error("call target wrong");
  call_slots_a: assert property (
    cl ##1 !discard_o |=> !ready_o && $stable(zero_flag_o) ##1 ready_o)
    else $error("call timing or flag wrong");
  zero_acc_a: assert property (
    tk && op == `CCD_OP_ZACC ##1 !discard_o |=> accum_o == 8'h00 && zero_flag_o)
    else $error("accumulator clear wrong");
  skip_flags_a: assert property (
    tk && op == `CCD_OP_DSKIP |-> ##2 $stable(zero_flag_o))
    else $error("skip moved zero flag");
  dec_file_a: assert property (
    tk && op == `CCD_OP_DEC && instr_i[7] ##1 !discard_o
      |=> file_we_o && file_wdata_o == $past(file_rdata_i) - 8'h01)
    else $error("decrement to file wrong");
  inv_acc_a: assert property (
    tk && op == `CCD_OP_INV && !instr_i[7] ##1 !discard_o
      |=> accum_o == ~$past(file_rdata_i) && zero_flag_o == (accum_o == 8'h00))
    else $error("invert to accumulator wrong");
  call_push_a: assert property (
    cl ##1 !discard_o |=> stack_top_o == $past(pc_i, 2) + 13'h0001)
    else $error("call pushed wrong return address");
  skip_nop_a: assert property (
    discard_o |=> !file_we_o && !pc_load_o && !watchdog_counter_clear_o
      && $stable(accum_o) && $stable(zero_flag_o))
    else $error("discarded word had an effect");

  kick_seen_c: cover property (kk);
  call_seen_c: cover property (cl);
  skip_seen_c: cover property (discard_o);
endmodule

bind ccd_exec ccd_exec_checker u_chk (.*);

// >>> tb/ccd_exec_tb.sv
// self-checking bench for the execution unit
// assumes ccd_exec with its checker bound; bench drives every input
`timescale 1ns/1ps
`include "ccd_consts.vh"

module ccd_exec_tb;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [12:0] pc_i = 13'h0000;
  logic [7:0]  upper_pc_latch_i = 8'h00;
  logic [7:0]  file_rdata_i = 8'h00;
  logic        watchdog_timeout_i = 1'b0;
  logic        sleep_entry_i = 1'b0;
  logic        stack_pop_i = 1'b0;
  wire  [6:0]  file_addr_o;
  wire  [7:0]  file_wdata_o, accum_o;
  wire  [12:0] pc_target_o, stack_top_o;
  wire         ready_o, file_we_o, zero_flag_o, pc_load_o, discard_o;
  wire         watchdog_expiry_flag_o, sleep_indicator_flag_o;
  wire         watchdog_counter_clear_o, prescaler_clear_o;
  int          fail_count = 0;
  int          tests_run = 0;

  ccd_exec u_dut (.*);

  // 4 ns clock
  always #2 clock_i = ~clock_i;

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // next edge, then let its updates land
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask

  // wait for an open slot, offer one word, return just after it is taken
  task automatic issue(input logic [13:0] w, input logic [7:0] rd);
    int n;
    n = 0;
    while (ready_o !== 1'b1) begin
      step();
      n++;
      if (n > 20) begin
        fail_count++;
        conclude();
      end
    end
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    file_rdata_i  <= rd;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  // one file or accumulator operation, checked one cycle after taking
  task automatic t_file(input logic [5:0] op, input logic d, input logic [7:0] rd,
                        input logic [7:0] ex, input logic z);
    logic [7:0] acc;
    acc = accum_o;
    issue({op, d, 7'h2a}, rd);
    check(file_addr_o, 13'h002a);
    check(discard_o, 1'b0);
    step();
    check(file_we_o, d);
    check(d ? file_wdata_o : accum_o, ex);
    if (d) check(accum_o, acc);
    check(zero_flag_o, z);
  endtask

  // call: push, target load, two slots, flags kept
  task automatic t_call(input logic [12:0] pc, input logic [7:0] lat,
                        input logic [10:0] k, input logic [12:0] tgt);
    logic z;
    z = zero_flag_o;
    @(posedge clock_i);
    pc_i             <= pc;
    upper_pc_latch_i <= lat;
    #1;
    issue({`CCD_CALL_PFX, k}, 8'h00);
    step();
    check(pc_load_o, 1'b1);
    check(pc_target_o, tgt);
    check(stack_top_o, pc + 13'h0001);
    check(ready_o, 1'b0);
    check(zero_flag_o, z);
    step();
    check(ready_o, 1'b1);
    check(pc_load_o, 1'b0);
  endtask

  // drop both status flags, then the kick must set them and pulse the clears
  task automatic t_kick();
    logic z;
    @(posedge clock_i);
    watchdog_timeout_i <= 1'b1;
    sleep_entry_i      <= 1'b1;
    @(posedge clock_i);
    watchdog_timeout_i <= 1'b0;
    sleep_entry_i      <= 1'b0;
    step();
    check(sleep_indicator_flag_o, 1'b0);
    check(watchdog_expiry_flag_o, 1'b0);
    z = zero_flag_o;
    issue({`CCD_OP_KICK, 8'h00}, 8'h00);
    step();
    check(watchdog_counter_clear_o, 1'b1);
    check(prescaler_clear_o, 1'b1);
    check(watchdog_expiry_flag_o, 1'b1);
    check(sleep_indicator_flag_o, 1'b1);
    check(zero_flag_o, z);
    step();
    check(prescaler_clear_o, 1'b0);
    check(watchdog_counter_clear_o, 1'b0);
  endtask

  // zero skip result: the next word runs as a nop
  task automatic t_skip();
    logic hit;
    t_file(`CCD_OP_DSKIP, 1'b0, 8'h01, 8'h00, 1'b0);
    issue({`CCD_OP_INV, 1'b0, 7'h2a}, 8'h00);
    hit = discard_o;
    step();
    check(hit | discard_o, 1'b1);
    check(accum_o, 8'h00);
    check(file_we_o, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    step();
    t_file(`CCD_OP_INV,   1'b1, 8'hff, 8'h00, 1'b1);
    t_file(`CCD_OP_DEC,   1'b0, 8'h3c, 8'h3b, 1'b0);
    t_file(`CCD_OP_ZACC,  1'b0, 8'h77, 8'h00, 1'b1);
    t_call(13'h0ffe, 8'h18, 11'h7ff, 13'h1fff);
    t_call(13'h0123, 8'h08, 11'h000, 13'h0800);
    @(posedge clock_i);
    stack_pop_i <= 1'b1;
    @(posedge clock_i);
    stack_pop_i <= 1'b0;
    step();
    check(stack_top_o, 13'h0fff);
    t_file(`CCD_OP_INV,   1'b0, 8'h5a, 8'ha5, 1'b0);
    t_kick();
    t_file(`CCD_OP_ZFILE, 1'b1, 8'h77, 8'h00, 1'b1);
    t_file(`CCD_OP_DSKIP, 1'b1, 8'h05, 8'h04, 1'b1);
    t_file(`CCD_OP_DEC,   1'b1, 8'h00, 8'hff, 1'b0);
    t_skip();
    conclude();
  end
endmodule
